// ==== adc_ext_dma_pkg.sv ====
package adc_ext_dma_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] CTRL1_OFFSET     = 8'h00;
    localparam logic [7:0] CTRL2_OFFSET     = 8'h04;
    localparam logic [7:0] CTRL4_OFFSET     = 8'h08;
    localparam logic [7:0] SCAN_HIGH_OFFSET = 8'h0C;
    localparam logic [7:0] SCAN_LOW_OFFSET  = 8'h10;
    localparam logic [7:0] RESULT_OFFSET    = 8'h14;
    localparam logic [7:0] STATUS_OFFSET    = 8'h18;

    // Field positions in converter_control_1.
    localparam int CTRL1_ON_BIT     = 15;
    localparam int CTRL1_BM_BIT     = 12;
    localparam int CTRL1_EN_BIT     = 11;
    localparam int CTRL1_RES_BIT    = 10;
    localparam int CTRL1_SAMPLE_BIT = 1;

    // Field positions in converter_control_2 and converter_control_4.
    localparam int CTRL2_ORG_BIT    = 11;
    localparam int CTRL2_HALF_BIT   = 7;
    localparam int CTRL2_COUNT_MSB  = 6;
    localparam int CTRL2_COUNT_LSB  = 2;
    localparam int CTRL2_SPLIT_BIT  = 1;
    localparam int CTRL4_LEN_MSB    = 2;
    localparam int CTRL4_LEN_LSB    = 0;

    // Field positions in the status register.
    localparam int STATUS_OVR_BIT   = 0;
    localparam int STATUS_REQ_BIT   = 1;

    // Reset values; the converter wakes up in 12-bit resolution.
    localparam logic [15:0] CTRL1_RESET = 16'h0400;
    localparam logic [15:0] CTRL2_RESET = 16'h0000;
    localparam logic [15:0] CTRL4_RESET = 16'h0000;
    localparam logic [15:0] SCAN_RESET  = 16'h0000;

    // Results held in each half of a split extended FIFO.
    localparam logic [4:0] FIFO_HALF_DEPTH = 5'h0D;

    typedef enum logic [2:0] {
        ROUTE_OFF = 3'b001,
        ROUTE_PIA = 3'b010,
        ROUTE_EXT = 3'b100
    } route_type;

    typedef struct packed {
        logic [15:0] data;
        logic [10:0] offset;
        logic [4:0]  channel;
    } dma_word_type;

endpackage : adc_ext_dma_pkg

`timescale 1ns/1ns
module indirect_offset_gen (
    input  wire logic [2:0]  len_i,
    input  wire logic [4:0]  chan_i,
    input  wire logic [6:0]  index_i,
    output logic      [10:0] offset_o
);
    logic [4:0] chan_keep;
    logic [9:0] word;

    always_comb begin
        case (len_i)
            3'h7:    chan_keep = {2'h0, chan_i[2:0]};
            3'h6:    chan_keep = {1'h0, chan_i[3:0]};
            default: chan_keep = chan_i;
        endcase
        word = (10'(chan_keep) << len_i) | (10'(index_i) & ((10'h001 << len_i) - 10'h001));
        offset_o = {word, 1'b0};
    end

endmodule : indirect_offset_gen

// ==== adc_ext_dma.sv ====
// Notes on behaviour
// - Extended DMA and buffer features act only while control 1 bit 11 is set.
// - Control 1 bit 12 picks extended buffer mode (1) or indirect-address mode (0).
// - Extended buffer mode sends all results, including channels above 13, to the DMA controller.
// - Buffer organisation bit picks FIFO or channel-aligned; samples field sets FIFO depth.
// - Split bit makes two FIFO halves of 13; half flag shows the half being filled.
// - Indirect-address mode produces an 11-bit offset ORed by DMA with its base.
// - Address space is contiguous equal buffers, one per channel, used or not.
// - Three-bit length field sets buffer size, 1 word at 000 to 128 at 111.
// - Offset is index under channel number, zero LSB, zero-filled up to 11 bits.
// - 32 channels for sizes up to 32 words, 16 for 64, 8 for 128.
// - Per-channel index auto-increments per write, wrapping by the smaller of the samples field and the buffer size.
// - Both 10-bit and 12-bit resolution exist, 12-bit after reset.
// - Resolution bit set gives 12-bit results, cleared gives 10-bit results.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module adc_ext_dma (
    input  wire logic                        ref_clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [7:0]                  paddr_i,
    input  wire logic [31:0]                 pwdata_i,
    output logic      [31:0]                 prdata_o,
    output logic                             pready_o,
    output logic                             pslverr_o,
    input  wire logic                        conv_done_i,
    input  wire logic [11:0]                 conv_result_i,
    input  wire logic [4:0]                  conv_channel_i,
    input  wire logic                        dma_ack_i,
    output logic                             dma_req_o,
    output adc_ext_dma_pkg::dma_word_type    dma_word_o,
    output logic                             converter_on_o,
    output logic                             sample_o,
    output logic                             resolution_12_o,
    output logic      [31:0]                 scan_channels_o
);
    import adc_ext_dma_pkg::*;

    logic [15:0]  ctrl1_reg, ctrl1_next;
    logic [15:0]  ctrl2_reg, ctrl2_next;
    logic [15:0]  ctrl4_reg, ctrl4_next;
    logic [15:0]  scan_high_reg, scan_high_next;
    logic [15:0]  scan_low_reg, scan_low_next;
    logic [15:0]  result_reg, result_next;
    logic [31:0]  prdata_reg, prdata_next;
    logic         pready_reg, pready_next;
    logic         pslverr_reg, pslverr_next;
    logic         req_reg, req_next;
    logic         ovr_reg, ovr_next;
    logic         sample_reg, sample_next;
    logic         half_reg, half_next;
    logic [4:0]   pos_reg, pos_next;
    logic [6:0]   index_reg [32];
    logic [6:0]   index_next [32];
    dma_word_type word_reg, word_next;

    logic         bus_write;
    logic         setup;
    logic         ext_enable;
    logic         ext_buffer_mode_sel;
    logic         resolution_select;
    logic         buffer_org_select;
    logic         fifo_split_enable;
    logic [4:0]   samples_per_interrupt;
    logic [2:0]   chan_buffer_length;
    logic [15:0]  scaled;
    logic [10:0]  pia_offset;
    logic [6:0]   index_limit;
    logic [4:0]   pos_limit;
    logic [4:0]   pos_eff;
    logic         accept;
    route_type    route;

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == CTRL1_OFFSET) || (addr == CTRL2_OFFSET) || (addr == CTRL4_OFFSET)
              || (addr == SCAN_HIGH_OFFSET) || (addr == SCAN_LOW_OFFSET)
              || (addr == RESULT_OFFSET) || (addr == STATUS_OFFSET);
    endfunction : mapped

    assign setup                 = psel_i & ~penable_i;
    assign bus_write             = psel_i & penable_i & pready_reg & pwrite_i;
    assign ext_enable            = ctrl1_reg[CTRL1_EN_BIT];
    assign ext_buffer_mode_sel   = ctrl1_reg[CTRL1_BM_BIT];
    assign resolution_select     = ctrl1_reg[CTRL1_RES_BIT];
    assign buffer_org_select     = ctrl2_reg[CTRL2_ORG_BIT];
    assign fifo_split_enable     = ctrl2_reg[CTRL2_SPLIT_BIT];
    assign samples_per_interrupt = ctrl2_reg[CTRL2_COUNT_MSB:CTRL2_COUNT_LSB];
    assign chan_buffer_length    = ctrl4_reg[CTRL4_LEN_MSB:CTRL4_LEN_LSB];

    indirect_offset_gen u_offset (
        .len_i    (chan_buffer_length),
        .chan_i   (conv_channel_i),
        .index_i  (index_reg[conv_channel_i]),
        .offset_o (pia_offset)
    );

    always_comb begin
        if (!ctrl1_reg[CTRL1_ON_BIT] || !ext_enable) begin
            route = ROUTE_OFF;
        end else if (ext_buffer_mode_sel) begin
            route = ROUTE_EXT;
        end else begin
            route = ROUTE_PIA;
        end
        if (resolution_select) begin
            scaled = {4'h0, conv_result_i};
        end else begin
            scaled = {6'h00, conv_result_i[11:2]};
        end
        // Wrap at the smaller of the sample count and the buffer size.
        index_limit = 7'((8'h01 << chan_buffer_length) - 8'h01);
        if ({2'h0, samples_per_interrupt} < index_limit) begin
            index_limit = {2'h0, samples_per_interrupt};
        end
        pos_limit = fifo_split_enable ? (FIFO_HALF_DEPTH - 5'h01) : samples_per_interrupt;
        pos_eff   = (fifo_split_enable && half_reg) ? (pos_reg + FIFO_HALF_DEPTH) : pos_reg;
        // A new result is taken only if none is pending or the pending one is being taken now; otherwise it is dropped.
        accept = conv_done_i && (route != ROUTE_OFF) && (!req_reg || dma_ack_i);
    end

    // Register file and APB slave.
    always_comb begin
        ctrl1_next     = ctrl1_reg;
        ctrl2_next     = ctrl2_reg;
        ctrl4_next     = ctrl4_reg;
        scan_high_next = scan_high_reg;
        scan_low_next  = scan_low_reg;
        result_next    = result_reg;
        ovr_next       = ovr_reg;
        pready_next    = setup & ~pready_reg;
        pslverr_next   = setup & ~pready_reg & ~mapped(paddr_i);
        prdata_next    = prdata_reg;
        if (setup && !pwrite_i) begin
            case (paddr_i)
                CTRL1_OFFSET:     prdata_next = {16'h0000, ctrl1_reg};
                CTRL2_OFFSET:     prdata_next = {16'h0000, ctrl2_reg[15:8], half_reg,
                                                 ctrl2_reg[6:0]};
                CTRL4_OFFSET:     prdata_next = {16'h0000, ctrl4_reg};
                SCAN_HIGH_OFFSET: prdata_next = {16'h0000, scan_high_reg};
                SCAN_LOW_OFFSET:  prdata_next = {16'h0000, scan_low_reg};
                RESULT_OFFSET:    prdata_next = {16'h0000, result_reg};
                STATUS_OFFSET:    prdata_next = {30'h0, req_reg, ovr_reg};
                default:          prdata_next = 32'h00000000;
            endcase
        end
        if (bus_write) begin
            case (paddr_i)
                CTRL1_OFFSET:     ctrl1_next = pwdata_i[15:0];
                CTRL2_OFFSET:     ctrl2_next = pwdata_i[15:0];
                CTRL4_OFFSET:     ctrl4_next = pwdata_i[15:0];
                SCAN_HIGH_OFFSET: scan_high_next = pwdata_i[15:0];
                SCAN_LOW_OFFSET:  scan_low_next = pwdata_i[15:0];
                STATUS_OFFSET:    ovr_next = ovr_reg & ~pwdata_i[STATUS_OVR_BIT];
                default:          ctrl1_next = ctrl1_reg;
            endcase
        end
        // Each finished conversion clears the sample bit unless software sets it again.
        if (conv_done_i && !(bus_write && paddr_i == CTRL1_OFFSET
                             && pwdata_i[CTRL1_SAMPLE_BIT])) begin
            ctrl1_next[CTRL1_SAMPLE_BIT] = 1'b0;
        end
        // Sampling is only shown while the converter is on.
        sample_next = ctrl1_next[CTRL1_SAMPLE_BIT] & ctrl1_next[CTRL1_ON_BIT];
        if (conv_done_i && ctrl1_reg[CTRL1_ON_BIT]) begin
            result_next = scaled;
        end
        if (conv_done_i && (route != ROUTE_OFF) && !accept) begin
            ovr_next = 1'b1;
        end
    end

    // Result routing towards the DMA controller.
    always_comb begin
        req_next  = req_reg & ~dma_ack_i;
        word_next = word_reg;
        half_next = half_reg;
        pos_next  = pos_reg;
        for (int c = 0; c < 32; c++) begin
            index_next[c] = index_reg[c];
        end
        if (accept) begin
            req_next          = 1'b1;
            word_next.data    = scaled;
            word_next.channel = conv_channel_i;
            case (route)
                ROUTE_PIA: begin
                    word_next.offset = pia_offset;
                    if (index_reg[conv_channel_i] >= index_limit) begin
                        index_next[conv_channel_i] = 7'h00;
                    end else begin
                        index_next[conv_channel_i] = index_reg[conv_channel_i] + 7'h01;
                    end
                end
                ROUTE_EXT: begin
                    if (buffer_org_select) begin
                        word_next.offset = {5'h00, conv_channel_i, 1'b0};
                    end else begin
                        word_next.offset = {5'h00, pos_eff, 1'b0};
                        if (pos_reg >= pos_limit) begin
                            pos_next = 5'h00;
                            if (fifo_split_enable) begin
                                half_next = ~half_reg;
                            end
                        end else begin
                            pos_next = pos_reg + 5'h01;
                        end
                    end
                end
                default: word_next = word_reg;
            endcase
        end
        if (route == ROUTE_OFF) begin
            pos_next  = 5'h00;
            half_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl1_reg     <= CTRL1_RESET;
            ctrl2_reg     <= CTRL2_RESET;
            ctrl4_reg     <= CTRL4_RESET;
            scan_high_reg <= SCAN_RESET;
            scan_low_reg  <= SCAN_RESET;
            result_reg    <= 16'h0000;
            prdata_reg    <= 32'h00000000;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            req_reg       <= 1'b0;
            ovr_reg       <= 1'b0;
            sample_reg    <= 1'b0;
            half_reg      <= 1'b0;
            pos_reg       <= 5'h00;
            word_reg      <= '0;
            for (int c = 0; c < 32; c++) begin
                index_reg[c] <= 7'h00;
            end
        end else begin
            ctrl1_reg     <= ctrl1_next;
            ctrl2_reg     <= ctrl2_next;
            ctrl4_reg     <= ctrl4_next;
            scan_high_reg <= scan_high_next;
            scan_low_reg  <= scan_low_next;
            result_reg    <= result_next;
            prdata_reg    <= prdata_next;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
            req_reg       <= req_next;
            ovr_reg       <= ovr_next;
            sample_reg    <= sample_next;
            half_reg      <= half_next;
            pos_reg       <= pos_next;
            word_reg      <= word_next;
            for (int c = 0; c < 32; c++) begin
                index_reg[c] <= index_next[c];
            end
        end
    end

    assign prdata_o        = prdata_reg;
    assign pready_o        = pready_reg;
    assign pslverr_o       = pslverr_reg;
    assign dma_req_o       = req_reg;
    assign dma_word_o      = word_reg;
    assign converter_on_o  = ctrl1_reg[CTRL1_ON_BIT];
    assign sample_o        = sample_reg;
    assign resolution_12_o = ctrl1_reg[CTRL1_RES_BIT];
    assign scan_channels_o = {scan_high_reg, scan_low_reg};

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    apb_ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("APB ready held longer than one cycle");
    ext_gate_off_a: assert property (
        (conv_done_i && !(converter_on_o && ext_enable) && !dma_req_o) |=> !dma_req_o)
        else $error("DMA request raised with extended features off");
    req_per_result_a: assert property (
        (conv_done_i && route != ROUTE_OFF && !dma_req_o)
        |=> dma_req_o && dma_word_o.channel == $past(conv_channel_i))
        else $error("Result did not raise one DMA request");
    offset_lsb_zero_a: assert property (
        dma_req_o |-> dma_word_o.offset[0] == 1'b0)
        else $error("Offset least significant bit not zero");
    pia_small_buf_a: assert property (
        (accept && route == ROUTE_PIA && chan_buffer_length == 3'h0)
        |=> dma_word_o.offset == {5'h00, $past(conv_channel_i), 1'b0})
        else $error("One-word buffer offset wrong");
    pia_eight_chan_a: assert property (
        (accept && route == ROUTE_PIA && chan_buffer_length == 3'h7)
        |=> dma_word_o.offset[10:8] == $past(conv_channel_i[2:0]))
        else $error("128-word buffer channel field wrong");
    half_toggle_wrap_a: assert property (
        (accept && route == ROUTE_EXT && !buffer_org_select && fifo_split_enable
         && pos_reg == 5'h0C) |=> half_reg != $past(half_reg) && pos_reg == 5'h00)
        else $error("Split FIFO half did not change after 13 results");
    res_default_a: assert property (
        $past(rst_i) |-> resolution_12_o)
        else $error("Resolution not 12-bit after reset");
    res_ten_bit_a: assert property (
        (accept && !resolution_select) |=> dma_word_o.data[15:10] == 6'h00)
        else $error("10-bit result wider than 10 bits");
    pia_index_step_a: assert property (
        (accept && route == ROUTE_PIA && index_reg[conv_channel_i] < index_limit)
        |=> index_reg[$past(conv_channel_i)] == $past(index_reg[conv_channel_i]) + 7'h01)
        else $error("Channel index did not advance");

    pia_request_c: cover property (accept && route == ROUTE_PIA ##1 dma_req_o);
    ext_split_wrap_c: cover property (accept && route == ROUTE_EXT && fifo_split_enable
                                      && pos_reg == 5'h0C);
    overrun_c: cover property (conv_done_i && dma_req_o && !dma_ack_i && route != ROUTE_OFF);

endmodule : adc_ext_dma

// ==== dma_ctrl_model.sv ====
`timescale 1ns/1ns
module dma_ctrl_model (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         stall_i,
    input  wire logic [15:0]                  dest_base_i,
    input  wire logic                         dma_req_i,
    input  wire adc_ext_dma_pkg::dma_word_type dma_word_i,
    output logic                              dma_ack_o,
    output logic      [15:0]                  last_addr_o,
    output logic      [15:0]                  last_data_o,
    output int                                count_o
);
    import adc_ext_dma_pkg::*;

    // Acknowledge is dropped after each taken word, so a held request is never taken twice.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_ack_o   <= 1'b0;
            last_addr_o <= 16'h0000;
            last_data_o <= 16'h0000;
            count_o     <= 0;
        end else begin
            dma_ack_o <= dma_req_i && !stall_i && !dma_ack_o;
            if (dma_req_i && dma_ack_o) begin
                last_addr_o <= dest_base_i | {5'h00, dma_word_i.offset};
                last_data_o <= dma_word_i.data;
                count_o     <= count_o + 1;
            end
        end
    end
endmodule : dma_ctrl_model

// ==== test_adc_extended_dma_addressing.sv ====
`timescale 1ns/1ns
module test_adc_extended_dma_addressing;
    import adc_ext_dma_pkg::*;

    localparam logic [15:0] BASE = 16'h1000;
    logic         clk       = 1'b0;
    logic         rst       = 1'b1;
    logic         psel      = 1'b0;
    logic         penable   = 1'b0;
    logic         pwrite    = 1'b0;
    logic [7:0]   paddr     = 8'h00;
    logic [31:0]  pwdata    = 32'h0;
    logic         conv_done = 1'b0;
    logic [11:0]  conv_res  = 12'h000;
    logic [4:0]   conv_ch   = 5'h00;
    logic         stall     = 1'b0;
    logic [31:0]  prdata, scan, rdat;
    logic         pready, pslverr, dma_req, dma_ack, conv_on, sample, res12, rerr;
    dma_word_type word;
    logic [15:0]  last_addr, last_data;
    int           dma_count, seen, err_count, n_compared;

    always #20 clk = ~clk;

    adc_ext_dma DUT (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .conv_done_i(conv_done),
        .conv_result_i(conv_res), .conv_channel_i(conv_ch), .dma_ack_i(dma_ack),
        .dma_req_o(dma_req), .dma_word_o(word), .converter_on_o(conv_on),
        .sample_o(sample), .resolution_12_o(res12), .scan_channels_o(scan));

    dma_ctrl_model far_end (.clk_i(clk), .rst_i(rst), .stall_i(stall), .dest_base_i(BASE),
        .dma_req_i(dma_req), .dma_word_i(word), .dma_ack_o(dma_ack),
        .last_addr_o(last_addr), .last_data_o(last_data), .count_o(dma_count));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1, "bus answer");
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic conv(input logic [4:0] ch, input logic [11:0] r);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_ch   <= ch;
        conv_res  <= r;
        @(posedge clk);
        conv_done <= 1'b0;
    endtask : conv

    task automatic take(input logic [15:0] addr, input logic [15:0] data);
        int n;
        n = 0;
        while (dma_count == seen && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) chk(32'h0, 32'h1, "dma answer");
        seen = dma_count;
        chk({16'h0, last_addr}, {16'h0, addr}, "dma address");
        chk({16'h0, last_data}, {16'h0, data}, "dma data");
    endtask : take

    function automatic logic [15:0] pia(input int len, input int ch, input int idx);
        int m;
        m = (len == 7) ? 7 : (len == 6) ? 15 : 31;
        return BASE | 16'(((((ch & m) << len) | idx) << 1));
    endfunction : pia

    task automatic t_reset;
        apb(1'b0, CTRL1_OFFSET, 32'h0);
        chk(rdat, 32'h0000_0400, "control 1 reset");
        chk({31'h0, res12}, 32'h1, "resolution after reset");
        apb(1'b0, 8'h1C, 32'h0);
        chk(rdat, 32'h0, "unmapped read data");
        chk({31'h0, rerr}, 32'h1, "unmapped error");
        $display("test reset done");
    endtask : t_reset

    task automatic t_pia;
        apb(1'b1, CTRL2_OFFSET, 32'h7C);
        apb(1'b1, CTRL1_OFFSET, 32'h8C00);
        for (int len = 0; len < 8; len++) begin
            apb(1'b1, CTRL4_OFFSET, 32'(len));
            for (int k = 0; k < 3; k++) begin
                conv(5'(len * 4 + 3), 12'hA50 + 12'(k));
                take(pia(len, len * 4 + 3, k % (1 << len)), 16'hA50 + 16'(k));
            end
        end
        $display("test indirect offsets done");
    endtask : t_pia

    task automatic t_res_dis;
        apb(1'b1, CTRL1_OFFSET, 32'h8800);
        @(posedge clk);
        chk({31'h0, res12}, 32'h0, "10-bit select");
        conv(5'd1, 12'hFFC);
        take(pia(7, 1, 0), 16'h03FF);
        apb(1'b1, CTRL1_OFFSET, 32'h8400);
        conv(5'd2, 12'h123);
        repeat (10) @(posedge clk);
        chk(32'(dma_count), 32'(seen), "request while disabled");
        apb(1'b0, RESULT_OFFSET, 32'h0);
        chk(rdat, 32'h123, "result register");
        $display("test resolution and disable done");
    endtask : t_res_dis

    task automatic ext_run(input logic [31:0] c2, input int n, input int wrap, input bit al);
        // Extended features off first, which clears the FIFO position and half flag.
        apb(1'b1, CTRL1_OFFSET, 32'h8400);
        apb(1'b1, CTRL2_OFFSET, c2);
        apb(1'b1, CTRL1_OFFSET, 32'h9C00);
        for (int k = 0; k < n; k++) begin
            conv(5'd20, 12'h300 + 12'(k));
            take(BASE | (al ? 16'd40 : 16'((k % wrap) << 1)), 16'h300 + 16'(k));
        end
    endtask : ext_run

    task automatic t_ext;
        ext_run(32'h87C, 2, 1, 1'b1);
        ext_run(32'h008, 4, 3, 1'b0);
        ext_run(32'h07E, 14, 26, 1'b0);
        apb(1'b0, CTRL2_OFFSET, 32'h0);
        chk({31'h0, rdat[7]}, 32'h1, "upper half filling");
        $display("test extended buffer done");
    endtask : t_ext

    task automatic t_overrun;
        apb(1'b1, CTRL1_OFFSET, 32'h8C00);
        stall <= 1'b1;
        conv(5'd5, 12'h055);
        conv(5'd5, 12'h066);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rdat, 32'h3, "overrun and pending");
        stall <= 1'b0;
        take(pia(7, 5, 0), 16'h0055);
        apb(1'b1, STATUS_OFFSET, 32'h1);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rdat, 32'h0, "overrun cleared");
        chk(32'(dma_count), 32'(seen), "dropped result");
        $display("test overrun done");
    endtask : t_overrun

    task automatic t_ctrl;
        apb(1'b1, SCAN_HIGH_OFFSET, 32'hBEEF);
        apb(1'b1, SCAN_LOW_OFFSET, 32'h1234);
        @(posedge clk);
        chk(scan, 32'hBEEF_1234, "scan select");
        apb(1'b1, CTRL1_OFFSET, 32'h8402);
        @(posedge clk);
        chk({30'h0, conv_on, sample}, 32'h3, "on and sampling");
        conv(5'd6, 12'h010);
        @(posedge clk);
        chk({31'h0, sample}, 32'h0, "sample cleared");
        $display("test controls done");
    endtask : t_ctrl

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    initial begin
        err_count  = 0;
        n_compared = 0;
        seen       = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_pia;
        t_res_dis;
        t_ext;
        t_overrun;
        t_ctrl;
        close_out;
    end

    initial begin
        #(40 * 20000);
        err_count++;
        close_out;
    end
endmodule : test_adc_extended_dma_addressing
